// ===== include/host_regs_pkg.sv
// Register map, field layout and carrier types of the host register bank
`default_nettype none
package host_regs_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned GPIN_W = 6;
	localparam int unsigned GPOUT_W = 8;
	localparam int unsigned SYNC_W = 1 + 1 + 1 + ADDR_W + DATA_W;

	// Write side addresses
	localparam logic [2:0] ADDR_COMMAND = 3'h0;
	localparam logic [2:0] ADDR_MODE_ONE = 3'h1;
	localparam logic [2:0] ADDR_MODE_TWO = 3'h2;
	localparam logic [2:0] ADDR_MODE_THREE = 3'h3;
	localparam logic [2:0] ADDR_GEN_OUTPUT = 3'h4;
	localparam logic [2:0] ADDR_UNUSED = 3'h5;
	localparam logic [2:0] ADDR_DATA_LOW = 3'h6;
	localparam logic [2:0] ADDR_DATA_HIGH = 3'h7;

	// Read side addresses
	localparam logic [2:0] ADDR_MAIN_STATUS = 3'h0;
	localparam logic [2:0] ADDR_STATUS_ONE = 3'h1;
	localparam logic [2:0] ADDR_STATUS_TWO = 3'h2;
	localparam logic [2:0] ADDR_STATUS_THREE = 3'h3;
	localparam logic [2:0] ADDR_X_INPUTS = 3'h4;
	localparam logic [2:0] ADDR_Y_INPUTS = 3'h5;
	localparam logic [2:0] ADDR_DATA_READ_LOW = 3'h6;
	localparam logic [2:0] ADDR_DATA_READ_HIGH = 3'h7;

	// Command register fields
	localparam int unsigned CMD_CODE_LSB = 0;
	localparam int unsigned CMD_CODE_W = 6;
	localparam int unsigned CMD_AXIS_X_BIT = 8;
	localparam int unsigned CMD_AXIS_Y_BIT = 9;
	localparam logic [5:0] AXIS_SELECT_CODE_DEFAULT = 6'h1f;

	// Input level field
	localparam int unsigned GPIN_LSB = 8;

	// Reset values
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] GEN_OUTPUT_RESET = 16'h0000;
	localparam logic [15:0] COMMAND_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [1:0] AXIS_SEL_RESET = 2'h1;

	typedef struct packed {
		logic [15:0] one;
		logic [15:0] two;
		logic [15:0] three;
	} axis_mode_t;

	typedef struct packed {
		logic [15:0] one;
		logic [15:0] two;
		logic [15:0] three;
	} axis_status_t;

	typedef struct packed {
		logic [5:0] code;
		logic [1:0] axes;
		logic [31:0] data;
	} command_t;
endpackage
`default_nettype wire

// ===== hw/axis_mode_bank.sv
// Three mode registers of one axis
`timescale 1ns/1ps
`default_nettype none
module axis_mode_bank
	import host_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic write_en,
	input wire logic [2:0] write_addr,
	input wire logic [15:0] write_data,
	output axis_mode_t mode
);
	axis_mode_t next_mode;

	always_comb begin
		next_mode = mode;
		if (write_en) begin
			unique case (write_addr)
				ADDR_MODE_ONE: next_mode.one = write_data;
				ADDR_MODE_TWO: next_mode.two = write_data;
				ADDR_MODE_THREE: next_mode.three = write_data;
				default: next_mode = mode;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode <= '{one: MODE_RESET, two: MODE_RESET, three: MODE_RESET};
		end else begin
			mode <= next_mode;
		end
	end
endmodule
`default_nettype wire

// ===== hw/host_register_bank.sv
// Host register bank: 16-bit parallel bus, mode, output, data and status registers
`timescale 1ns/1ps
`default_nettype none
module host_register_bank
	import host_regs_pkg::*;
#(
	parameter logic [5:0] AXIS_SELECT_CODE = AXIS_SELECT_CODE_DEFAULT
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [2:0] addr,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe,
	output logic [7:0] general_output_pin,
	input wire logic [5:0] x_general_in,
	input wire logic [5:0] y_general_in,
	input wire logic [15:0] main_status,
	input wire axis_status_t x_status,
	input wire axis_status_t y_status,
	input wire logic [31:0] data_read,
	output axis_mode_t x_mode,
	output axis_mode_t y_mode,
	output command_t command,
	output logic command_valid
);
	// Pin synchronisers: bus pins and general inputs
	logic [SYNC_W-1:0] bus_meta;
	logic [SYNC_W-1:0] bus_sync;
	logic [SYNC_W-1:0] bus_last;
	logic [11:0] gpin_meta;
	logic [11:0] gpin_sync;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bus_meta <= {3'h7, {(SYNC_W-3){1'b0}}};
			bus_sync <= {3'h7, {(SYNC_W-3){1'b0}}};
			bus_last <= {3'h7, {(SYNC_W-3){1'b0}}};
			gpin_meta <= 12'h000;
			gpin_sync <= 12'h000;
		end else begin
			bus_meta <= {cs_n, wr_n, rd_n, addr, data_in};
			bus_sync <= bus_meta;
			bus_last <= bus_sync;
			gpin_meta <= {y_general_in, x_general_in};
			gpin_sync <= gpin_meta;
		end
	end

	logic cs_s;
	logic wr_s;
	logic rd_s;
	logic [2:0] addr_s;
	logic cs_l;
	logic wr_l;
	logic [2:0] addr_l;
	logic [15:0] data_l;
	logic [5:0] x_in_s;
	logic [5:0] y_in_s;

	assign cs_s = ~bus_sync[SYNC_W-1];
	assign wr_s = ~bus_sync[SYNC_W-2];
	assign rd_s = ~bus_sync[SYNC_W-3];
	assign addr_s = bus_sync[DATA_W +: ADDR_W];
	assign cs_l = ~bus_last[SYNC_W-1];
	assign wr_l = ~bus_last[SYNC_W-2];
	assign addr_l = bus_last[DATA_W +: ADDR_W];
	assign data_l = bus_last[DATA_W-1:0];
	assign x_in_s = gpin_sync[5:0];
	assign y_in_s = gpin_sync[11:6];

	// Write taken at the trailing edge of the strobe, last sampled address and data
	logic wr_strobe;
	logic rd_active;
	assign wr_strobe = cs_l & wr_l & ~wr_s;
	assign rd_active = cs_s & rd_s;

	// Write-side registers
	logic [15:0] command_reg;
	logic [15:0] general_output_reg;
	logic [15:0] data_write_low;
	logic [15:0] data_write_high;
	logic [1:0] axis_sel;
	logic [15:0] next_command_reg;
	logic [15:0] next_general_output_reg;
	logic [15:0] next_data_write_low;
	logic [15:0] next_data_write_high;
	logic [1:0] next_axis_sel;
	logic next_command_valid;
	command_t next_command;

	always_comb begin
		next_command_reg = command_reg;
		next_general_output_reg = general_output_reg;
		next_data_write_low = data_write_low;
		next_data_write_high = data_write_high;
		next_axis_sel = axis_sel;
		next_command_valid = 1'b0;
		next_command = command;
		if (wr_strobe) begin
			unique case (addr_l)
				ADDR_COMMAND: begin
					next_command_reg = data_l;
					next_axis_sel = {data_l[CMD_AXIS_Y_BIT], data_l[CMD_AXIS_X_BIT]};
					if (data_l[CMD_CODE_LSB +: CMD_CODE_W] != AXIS_SELECT_CODE) begin
						next_command_valid = 1'b1;
						next_command.code = data_l[CMD_CODE_LSB +: CMD_CODE_W];
						next_command.axes = {data_l[CMD_AXIS_Y_BIT], data_l[CMD_AXIS_X_BIT]};
						next_command.data = {data_write_high, data_write_low};
					end
				end
				ADDR_GEN_OUTPUT: next_general_output_reg = data_l;
				ADDR_DATA_LOW: next_data_write_low = data_l;
				ADDR_DATA_HIGH: next_data_write_high = data_l;
				ADDR_UNUSED: next_command_reg = command_reg;
				default: next_command_reg = command_reg;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			command_reg <= COMMAND_RESET;
			general_output_reg <= GEN_OUTPUT_RESET;
			data_write_low <= DATA_RESET;
			data_write_high <= DATA_RESET;
			axis_sel <= AXIS_SEL_RESET;
			command_valid <= 1'b0;
			command <= '0;
		end else begin
			command_reg <= next_command_reg;
			general_output_reg <= next_general_output_reg;
			data_write_low <= next_data_write_low;
			data_write_high <= next_data_write_high;
			axis_sel <= next_axis_sel;
			command_valid <= next_command_valid;
			command <= next_command;
		end
	end

	assign general_output_pin = general_output_reg[GPOUT_W-1:0];

	// mode writes routed by the axis select
	logic mode_write;
	assign mode_write = wr_strobe && (addr_l == ADDR_MODE_ONE || addr_l == ADDR_MODE_TWO ||
		addr_l == ADDR_MODE_THREE);

	axis_mode_bank x_bank (
		.mclk(mclk),
		.nrst(nrst),
		.write_en(mode_write & axis_sel[0]),
		.write_addr(addr_l),
		.write_data(data_l),
		.mode(x_mode)
	);

	axis_mode_bank y_bank (
		.mclk(mclk),
		.nrst(nrst),
		.write_en(mode_write & axis_sel[1]),
		.write_addr(addr_l),
		.write_data(data_l),
		.mode(y_mode)
	);

	// Read side: registered data, driven while the host reads
	axis_status_t sel_status;
	logic [15:0] next_data_out;
	logic next_data_oe;

	// status copy of the selected axis, X first
	assign sel_status = axis_sel[0] ? x_status : y_status;

	always_comb begin
		next_data_oe = rd_active;
		next_data_out = data_out;
		if (rd_active) begin
			unique case (addr_s)
				ADDR_MAIN_STATUS: next_data_out = main_status;
				ADDR_STATUS_ONE: next_data_out = sel_status.one;
				ADDR_STATUS_TWO: next_data_out = sel_status.two;
				ADDR_STATUS_THREE: next_data_out = sel_status.three;
				ADDR_X_INPUTS: next_data_out = {2'h0, x_in_s, 8'h00};
				ADDR_Y_INPUTS: next_data_out = {2'h0, y_in_s, 8'h00};
				ADDR_DATA_READ_LOW: next_data_out = data_read[15:0];
				ADDR_DATA_READ_HIGH: next_data_out = data_read[31:16];
				default: next_data_out = data_out;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			data_out <= 16'h0000;
			data_oe <= 1'b0;
		end else begin
			data_out <= next_data_out;
			data_oe <= next_data_oe;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	gen_output_write_a: assert property (
		wr_strobe && addr_l == ADDR_GEN_OUTPUT |=> ##1
		general_output_pin == $past(data_l[7:0], 2))
		else $error("general output pins do not follow the write");

	unused_write_a: assert property (
		wr_strobe && addr_l == ADDR_UNUSED |=>
		$stable(general_output_pin) && $stable(x_mode) && $stable(y_mode) &&
		$stable(command_reg) && $stable(data_write_low) && $stable(data_write_high))
		else $error("write to unused address changed a register");

	data_words_a: assert property (
		wr_strobe && addr_l == ADDR_COMMAND &&
		data_l[CMD_CODE_LSB +: CMD_CODE_W] != AXIS_SELECT_CODE |=>
		command_valid && command.data == $past({data_write_high, data_write_low}))
		else $error("command parameter not built from data words");

	select_no_cmd_a: assert property (
		wr_strobe && addr_l == ADDR_COMMAND &&
		data_l[CMD_CODE_LSB +: CMD_CODE_W] == AXIS_SELECT_CODE |=> !command_valid)
		else $error("axis select command issued to the core");

	mode_route_a: assert property (
		wr_strobe && addr_l == ADDR_MODE_ONE && axis_sel == 2'h1 |=>
		x_mode.one == $past(data_l) && $stable(y_mode))
		else $error("mode write not routed to selected axis only");

	status_select_a: assert property (
		rd_active && addr_s == ADDR_STATUS_TWO && axis_sel == 2'h2 |=>
		data_out == $past(y_status.two))
		else $error("status read not from selected axis");

	input_level_a: assert property (
		rd_active && addr_s == ADDR_X_INPUTS |=>
		data_out[13:8] == $past(x_in_s) && data_out[15:14] == 2'h0 && data_out[7:0] == 8'h00)
		else $error("input register does not show input levels");

	main_status_a: assert property (
		rd_active && addr_s == ADDR_MAIN_STATUS |=> data_out == $past(main_status))
		else $error("main status not returned");

	read_enable_a: assert property (
		!cs_s || !rd_s |=> !data_oe)
		else $error("data bus driven outside a read");

	read_drive_a: assert property (
		rd_active |=> data_oe)
		else $error("data bus not driven during a read");

	select_update_a: assert property (
		wr_strobe && addr_l == ADDR_COMMAND |=>
		axis_sel == $past({data_l[CMD_AXIS_Y_BIT], data_l[CMD_AXIS_X_BIT]}))
		else $error("axis select not taken from command write");

	mode_two_route_a: assert property (
		wr_strobe && addr_l == ADDR_MODE_TWO && axis_sel == 2'h2 |=>
		y_mode.two == $past(data_l) && $stable(x_mode))
		else $error("mode two write not routed to selected axis only");

	mode_three_route_a: assert property (
		wr_strobe && addr_l == ADDR_MODE_THREE && axis_sel == 2'h1 |=>
		x_mode.three == $past(data_l) && $stable(y_mode))
		else $error("mode three write not routed to selected axis only");

	status_one_a: assert property (
		rd_active && addr_s == ADDR_STATUS_ONE && axis_sel == 2'h1 |=>
		data_out == $past(x_status.one))
		else $error("status one not from selected axis");

	data_read_high_a: assert property (
		rd_active && addr_s == ADDR_DATA_READ_HIGH |=> data_out == $past(data_read[31:16]))
		else $error("data high word not returned");
endmodule
`default_nettype wire

// ===== sim/host_cpu_model.sv
// Host processor model driving the parallel register bus
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model(
	input wire logic mclk,
	output logic cs_n,
	output logic wr_n,
	output logic rd_n,
	output logic [2:0] addr,
	output logic [15:0] drive,
	output logic drive_en,
	input wire logic [15:0] bus
);
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		addr = 3'h0;
		drive = 16'h0000;
		drive_en = 1'b0;
	end
	// Strobe low three cycles, address and data held two past release
	task automatic write_reg(input logic [2:0] a, input logic [15:0] d);
		@(negedge mclk);
		cs_n = 1'b0;
		wr_n = 1'b0;
		addr = a;
		drive = d;
		drive_en = 1'b1;
		repeat (3) @(negedge mclk);
		wr_n = 1'b1;
		repeat (2) @(negedge mclk);
		cs_n = 1'b1;
		drive_en = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task automatic read_reg(input logic [2:0] a, output logic [15:0] d);
		@(negedge mclk);
		cs_n = 1'b0;
		rd_n = 1'b0;
		addr = a;
		repeat (5) @(negedge mclk);
		d = bus;
		rd_n = 1'b1;
		cs_n = 1'b1;
		repeat (4) @(negedge mclk);
	endtask
	task automatic select_axis(input logic sel_y);
		write_reg(3'h0, {6'h00, sel_y, ~sel_y, 2'h0, 6'h1f});
	endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench of the host register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	import host_regs_pkg::*;
	logic mclk, nrst, cs_n, wr_n, rd_n, drive_en, data_oe, command_valid, sel;
	logic [2:0] addr;
	logic [15:0] drive, bus, data_out, main_status, w, lo, hi, rd;
	logic [7:0] general_output_pin, ex_out;
	logic [5:0] x_in, y_in, c;
	logic [31:0] data_read, seed;
	axis_status_t x_status, y_status;
	axis_mode_t x_mode, y_mode;
	command_t command, last_cmd;
	logic [15:0] ex [2][3];
	int n_mismatch, num_checks, n_cmd, k;
	// Pulled-up bus when nobody drives
	assign bus = data_oe ? data_out : (drive_en ? drive : 16'hffff);
	host_register_bank i_host_register_bank(.mclk(mclk), .nrst(nrst), .cs_n(cs_n),
		.wr_n(wr_n), .rd_n(rd_n), .addr(addr), .data_in(bus), .data_out(data_out),
		.data_oe(data_oe), .general_output_pin(general_output_pin), .x_general_in(x_in),
		.y_general_in(y_in), .main_status(main_status), .x_status(x_status),
		.y_status(y_status), .data_read(data_read), .x_mode(x_mode), .y_mode(y_mode),
		.command(command), .command_valid(command_valid));
	host_cpu_model host(.mclk(mclk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
		.drive(drive), .drive_en(drive_en), .bus(bus));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] exp_read(input logic [2:0] a, input logic sy);
		axis_status_t s;
		s = sy ? y_status : x_status;
		case (a)
			3'h0: return main_status;
			3'h1: return s.one;
			3'h2: return s.two;
			3'h3: return s.three;
			3'h4: return {2'h0, x_in, 8'h00};
			3'h5: return {2'h0, y_in, 8'h00};
			3'h6: return data_read[15:0];
			default: return data_read[31:16];
		endcase
	endfunction
	task automatic check(input string what, input logic [47:0] e, input logic [47:0] got);
		num_checks++;
		if (got !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, e, got);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d checks %0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic shake();
		@(negedge mclk);
		{x_in, y_in} = 12'(rnd());
		main_status = 16'(rnd());
		x_status = {rnd(), 16'(rnd())};
		y_status = {rnd(), 16'(rnd())};
		data_read = rnd();
	endtask
	task automatic check_modes();
		check("x_mode", {ex[0][0], ex[0][1], ex[0][2]}, x_mode);
		check("y_mode", {ex[1][0], ex[1][1], ex[1][2]}, y_mode);
		check("outputs", ex_out, general_output_pin);
	endtask
	// Count command pulses mid-cycle
	always @(negedge mclk) begin
		if (command_valid === 1'b1) begin
			n_cmd++;
			last_cmd = command;
		end
	end
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		finish_test();
	end
	initial begin
		nrst = 1'b0;
		seed = 32'd79658;
		{x_in, y_in, main_status, x_status, y_status, data_read} = '0;
		ex = '{default: 16'h0000};
		ex_out = 8'h00;
		repeat (8) @(negedge mclk);
		nrst = 1'b1;
		check_modes();
		for (k = 0; k < 4; k++) begin
			sel = k[0];
			host.select_axis(sel);
			for (int a = 1; a < 4; a++) begin
				w = 16'(rnd());
				ex[sel][a-1] = w;
				host.write_reg(3'(a), w);
			end
			w = 16'(rnd());
			ex_out = w[7:0];
			host.write_reg(3'h4, w);
			check_modes();
			host.write_reg(3'h5, 16'(rnd()));
			check_modes();
			check("pulses", 48'(0), 48'(n_cmd));
			lo = 16'(rnd());
			hi = 16'(rnd());
			c = 6'(rnd()) & 6'h1e;
			host.write_reg(3'h6, lo);
			host.write_reg(3'h7, hi);
			host.write_reg(3'h0, {6'h00, sel, ~sel, 2'h0, c});
			check("cmd count", 48'(1), 48'(n_cmd));
			check("command", {c, sel, ~sel, hi, lo}, last_cmd);
			n_cmd = 0;
			for (int a = 0; a < 8; a++) begin
				shake();
				host.read_reg(3'(a), rd);
				check("read", exp_read(3'(a), sel), rd);
				check("data_oe", 48'(0), 48'(data_oe));
			end
		end
		// Mid-run reset clears modes and outputs again
		@(negedge mclk);
		nrst = 1'b0;
		ex = '{default: 16'h0000};
		ex_out = 8'h00;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		check_modes();
		finish_test();
	end
endmodule
`default_nettype wire
